/* bench/tic_cpu_model.sv */
// CPU core model: port instructions and instruction ends
`timescale 1ns/1ps
module tic_cpu_model
  import tic_pkg::*;
(
  // Clock and read data
  input  wire logic       CLOCK_I,
  input  wire logic [7:0] RDATA_I,
  // Port bus and handshake
  output tic_io_req_t     IO_REQ_O,
  output logic            GATE_O,
  output logic            DONE_O
);
  initial begin
    IO_REQ_O = '0;
    GATE_O   = 1'b0;
    DONE_O   = 1'b0;
  end
  task automatic io(input logic w, input logic [3:0] p, input logic [7:0] d,
                    output logic [7:0] q);
    @(negedge CLOCK_I);
    IO_REQ_O = '{w, !w, p, d};
    @(negedge CLOCK_I);
    // Idle bus shows inverted data, never the old value
    IO_REQ_O = '{1'b0, 1'b0, ~p, ~d};
    q = RDATA_I;
  endtask : io
  task automatic done(input logic g);
    @(negedge CLOCK_I);
    GATE_O = g;
    DONE_O = 1'b1;
    @(negedge CLOCK_I);
    DONE_O = 1'b0;
  endtask : done
endmodule : tic_cpu_model

/* bench/tic_timer_assertions.sv */
// Port-level checks for the timer
`timescale 1ns/1ps
module tic_timer_assertions
  import tic_pkg::*;
(
  // Clock, reset, port bus
  input wire logic        CLOCK_I,
  input wire logic        RSTN_I,
  input wire tic_io_req_t IO_REQ_I,
  input wire logic [7:0]  IO_RDATA_O,
  // Handshake and pin
  input wire logic        IRQ_GATE_FLAG_I,
  input wire logic        INSTR_DONE_I,
  input wire logic        TIMER_IRQ_O,
  input wire logic        EXT_IRQ_O,
  input wire logic        IRQ_ACK_TIMER_O,
  input wire logic        IRQ_ACK_EXT_O,
  input wire logic        EXTERNAL_IRQ_PIN_I
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_wr(logic [3:0] p); IO_REQ_I.wr && IO_REQ_I.port == p; endsequence
  sequence s_take; INSTR_DONE_I && IRQ_GATE_FLAG_I; endsequence
  property p_rd; IO_RDATA_O != 8'h00 |-> $past(IO_REQ_I.rd); endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  property p_ctl; s_wr(4'h6) or IO_REQ_I.rd && IO_REQ_I.port == 4'h6 |=> IO_RDATA_O[6:0] == 7'h00;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control read not zero");
  property p_ackt; s_take ##0 TIMER_IRQ_O |=> IRQ_ACK_TIMER_O && !TIMER_IRQ_O; endproperty
  a_ackt: assert property (p_ackt) else $error("timer ack wrong");
  property p_acke; IRQ_ACK_EXT_O |-> $past(EXT_IRQ_O && !TIMER_IRQ_O && INSTR_DONE_I && IRQ_GATE_FLAG_I);
  endproperty
  a_acke: assert property (p_acke) else $error("ext ack wrong");
  property p_gate; !IRQ_GATE_FLAG_I |=> !IRQ_ACK_TIMER_O && !IRQ_ACK_EXT_O; endproperty
  a_gate: assert property (p_gate) else $error("ack with gate low");
  property p_wr7; s_wr(4'h7) |-> ##[1:3] !TIMER_IRQ_O; endproperty
  a_wr7: assert property (p_wr7) else $error("load kept timer request");
  property p_ent; s_wr(4'h6) ##0 !IO_REQ_I.data[1] |-> ##[1:3] !TIMER_IRQ_O; endproperty
  a_ent: assert property (p_ent) else $error("timer request not gated");
  property p_ene; s_wr(4'h6) ##0 !IO_REQ_I.data[0] |-> ##2 !EXT_IRQ_O [*2]; endproperty
  a_ene: assert property (p_ene) else $error("ext request kept");
endmodule : tic_timer_assertions

/* bench/tic_timer_tb_top.sv */
// Self-checking bench for the timer
`timescale 1ns/1ps
module tic_timer_tb_top;
  import tic_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        pin = 1'b0;
  logic        gate, done, tirq, eirq, tack, eack;
  logic [7:0]  rdata, q;
  tic_io_req_t req;
  int          n_fail = 0;
  int          checks = 0;
  // Ctrl, load, steps, divider, expected count
  logic [7:0]  rows [7][5] = '{'{8'h28, 8'h10, 3, 2, 8'h0d}, '{8'h48, 8'h20, 2, 5, 8'h1e},
    '{8'h68, 8'h00, 1, 10, 8'hff}, '{8'h88, 8'h08, 1, 20, 8'h07},
    '{8'ha8, 8'h05, 1, 40, 8'h04}, '{8'he8, 8'h02, 1, 200, 8'h01},
    '{8'h2a, 8'h03, 4, 2, 8'h02}};
  always #25 clk = ~clk;
  tic_cpu_model i_tic_cpu_model (.CLOCK_I(clk), .RDATA_I(rdata), .IO_REQ_O(req),
    .GATE_O(gate), .DONE_O(done));
  tic_timer i_tic_timer (.CLOCK_I(clk), .RSTN_I(rstn), .IO_REQ_I(req), .IO_RDATA_O(rdata),
    .IRQ_GATE_FLAG_I(gate), .INSTR_DONE_I(done), .TIMER_IRQ_O(tirq), .EXT_IRQ_O(eirq),
    .IRQ_ACK_TIMER_O(tack), .IRQ_ACK_EXT_O(eack), .EXTERNAL_IRQ_PIN_I(pin));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] p, input logic [7:0] d);
    i_tic_cpu_model.io(1'b1, p, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] p);
    i_tic_cpu_model.io(1'b0, p, 8'h00, q);
  endtask : rd
  task automatic hold(input logic v, input int n);
    @(negedge clk);
    pin = v;
    repeat (n) @(negedge clk);
  endtask : hold
  task automatic print_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    chk({4'h0, tirq, eirq, tack, eack}, 8'h00);
    rd(4'h6);
    chk(q, 8'h00);
    $display("end reset");
    // Sample mid-step so phase alignment cannot tip the count
    for (int i = 0; i < 7; i++) begin
      wr(4'h6, 8'h00);
      wr(4'h7, rows[i][1]);
      wr(4'h6, rows[i][0]);
      repeat (rows[i][2] * 2 * rows[i][3] + rows[i][3] - 1) @(negedge clk);
      rd(4'h7);
      chk(q, rows[i][4]);
      chk({7'h00, tirq}, {7'h00, rows[i][0][1]});
    end
    $display("end rows");
    wr(4'h6, 8'h02);
    i_tic_cpu_model.done(1'b0);
    chk({7'h00, tack}, 8'h00);
    i_tic_cpu_model.done(1'b1);
    chk({6'h00, tack, tirq}, 8'h02);
    $display("end ack");
    hold(1'b1, 6);
    rd(4'h6);
    chk(q, 8'h80);
    wr(4'h6, 8'h05);
    hold(1'b0, 6);
    hold(1'b1, 8);
    chk({7'h00, eirq}, 8'h01);
    i_tic_cpu_model.done(1'b1);
    chk({6'h00, eack, eirq}, 8'h02);
    hold(1'b0, 6);
    hold(1'b1, 8);
    wr(4'h6, 8'h04);
    repeat (3) @(negedge clk);
    chk({7'h00, eirq}, 8'h00);
    $display("end ext");
    wr(4'h7, 8'h05);
    wr(4'h6, 8'h0c);
    for (int i = 0; i < 3; i++) begin
      hold(1'b0, 6);
      hold(1'b1, 6);
    end
    rd(4'h7);
    chk(q, 8'h02);
    $display("end event");
    hold(1'b0, 6);
    wr(4'h7, 8'h32);
    wr(4'h6, 8'h3d);
    hold(1'b0, 10);
    rd(4'h7);
    chk(q, 8'h32);
    hold(1'b1, 41);
    hold(1'b0, 10);
    rd(4'h7);
    chk(q, 8'h28);
    chk({7'h00, eirq}, 8'h01);
    $display("end pulse");
    print_verdict();
  end
endmodule : tic_timer_tb_top
bind tic_timer tic_timer_assertions i_tic_timer_assertions (.*);

/* core/tic_consts.svh */
// Constants for the timer and interrupt control port
`ifndef TIC_CONSTS_SVH
`define TIC_CONSTS_SVH

`define TIC_PORT_CTRL     4'h6
`define TIC_PORT_TIMER    4'h7
`define TIC_CTRL_RESET    8'h00
`define TIC_BIT_EXT_EN    0
`define TIC_BIT_TMR_EN    1
`define TIC_BIT_LEVEL     2
`define TIC_BIT_RUN       3
`define TIC_BIT_PULSE     4
`define TIC_BIT_DIV2      5
`define TIC_BIT_DIV5      6
`define TIC_BIT_DIV20     7
`define TIC_DIV2          8'h02
`define TIC_DIV5          8'h05
`define TIC_DIV20         8'h14
`define TIC_COUNT_ONE     8'h01
`define TIC_PSC_ZERO      8'h00
`define TIC_PSC_ONE       8'h01
`define TIC_PSC_WIDTH     8

`endif

/* core/tic_pkg.sv */
// Types shared by the timer and interrupt control port
package tic_pkg;

  // Port access from the CPU core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] port;
    logic [7:0] data;
  } tic_io_req_t;

  // Decoded timer mode
  typedef enum logic [1:0] {
    TIC_MODE_INTERVAL,
    TIC_MODE_PULSE,
    TIC_MODE_EVENT
  } tic_mode_t;

endpackage : tic_pkg

/* core/tic_timer.sv */
// Timer, prescaler and interrupt control port of the single-chip controller
//
// Notes on behaviour
// - 8-bit down counter, three software modes
// - Port 6 write latches control byte
// - Bit0 external enable, bit1 timer enable
// - Bit2 pin level, bit3 run, bit4 pulse
// - Bits 5,6,7 divide by 2,5,20
// - Combined prescale bits multiply their factors
// - Port 6 read: zeros, pin level bit7
// - Prescaler reset: stop, port 7, trailing edge
// - Port 7 write loads counter, reload, clears
// - Prescaler clocks timer except event mode
// - Phase clock is half time base
// - Interval mode counts down from reload
// - After 01 reload instead of zero
// - Port 7 read returns current count
// - Acknowledge only while gate flag set
// - Free-running timer has no cumulative drift
// - Reload sets timer latch, gated by bit1
// - Pulse mode counts while pin active
// - Event mode counts inactive-to-active edges
// - External latch on edge, cleared by disable
//
// Timing in brief
// - Phase tick on every second clock, so one
//   prescaler count takes two system clocks.
// - A step of the counter takes 2*div clocks.
// - Pin edges land three to four clocks late,
//   a cost of the three-flop synchroniser.
// - Port reads answer one clock after the strobe.
// - Requests and acknowledges are registered, so
//   the CPU sees each change one clock later.
// - Stopping the timer drops the partial prescale
//   count; repeated stops lose time on purpose.
// - Mode: bit 4 set is pulse width; otherwise any
//   prescale bit gives interval, none gives events.
// - Pulse width with no prescale bit counts phase
//   ticks directly; a corner left undefined.
// - The timer latch keeps a request while bit 1 is
//   clear; the external latch does not.
`timescale 1ns/1ps
`include "tic_consts.svh"

module tic_timer
  import tic_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RSTN_I,
  // Port access from the CPU core
  input  wire tic_io_req_t IO_REQ_I,
  output logic [7:0]       IO_RDATA_O,
  // Interrupt handshake with the CPU core
  input  wire logic        IRQ_GATE_FLAG_I,
  input  wire logic        INSTR_DONE_I,
  output logic             TIMER_IRQ_O,
  output logic             EXT_IRQ_O,
  output logic             IRQ_ACK_TIMER_O,
  output logic             IRQ_ACK_EXT_O,
  // External pin
  input  wire logic        EXTERNAL_IRQ_PIN_I
);

  // ==========================================================
  // Control port
  logic [7:0] irq_timer_ctrl_port;

  // Counter, reload register and prescaler
  logic [7:0] count;
  logic [7:0] reload;
  logic [7:0] psc;
  logic       phase;

  // Request latches
  logic       timer_latch;
  logic       ext_latch;

  // Pin synchroniser stages and settled level
  logic       s1;
  logic       s2;
  logic       s3;
  logic       pin_lvl;
  logic       pin_lvl_d;

  // Decoded port strobes
  logic       wr_ctrl;
  logic       wr_timer;
  logic       rd_ctrl;
  logic       rd_timer;

  // Decoded control fields
  logic       run;
  logic       ext_en;
  logic       tmr_en;
  tic_mode_t  mode;

  assign wr_ctrl  = IO_REQ_I.wr && (IO_REQ_I.port == `TIC_PORT_CTRL);
  assign wr_timer = IO_REQ_I.wr && (IO_REQ_I.port == `TIC_PORT_TIMER);
  assign rd_ctrl  = IO_REQ_I.rd && (IO_REQ_I.port == `TIC_PORT_CTRL);
  assign rd_timer = IO_REQ_I.rd && (IO_REQ_I.port == `TIC_PORT_TIMER);

  assign run      = irq_timer_ctrl_port[`TIC_BIT_RUN];

  assign ext_en   = irq_timer_ctrl_port[`TIC_BIT_EXT_EN];
  assign tmr_en   = irq_timer_ctrl_port[`TIC_BIT_TMR_EN];

  // mode decode from bit 4 and prescale bits
  logic psc_any;
  assign psc_any = |irq_timer_ctrl_port[`TIC_BIT_DIV20:`TIC_BIT_DIV2];

  always_comb begin
    unique case ({irq_timer_ctrl_port[`TIC_BIT_PULSE], psc_any})
      2'b00:   mode = TIC_MODE_EVENT;
      2'b01:   mode = TIC_MODE_INTERVAL;
      default: mode = TIC_MODE_PULSE;
    endcase
  end

  // latch control byte; cleared at reset
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      irq_timer_ctrl_port <= `TIC_CTRL_RESET;
    else if (wr_ctrl)
      irq_timer_ctrl_port <= IO_REQ_I.data;
  end

  // ==========================================================
  // Pin synchroniser
  // three flops, change taken when last two agree
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= EXTERNAL_IRQ_PIN_I;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      pin_lvl <= 1'b0;
    else if (s2 == s3)
      pin_lvl <= s3;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      pin_lvl_d <= 1'b0;
    else
      pin_lvl_d <= pin_lvl;
  end

  // ==========================================================
  // Edge detection
  // active level chosen by bit 2
  logic pin_act;
  logic pin_act_d;
  logic lead_edge;
  logic trail_edge;
  assign pin_act    = pin_lvl ~^ irq_timer_ctrl_port[`TIC_BIT_LEVEL];
  assign pin_act_d  = pin_lvl_d ~^ irq_timer_ctrl_port[`TIC_BIT_LEVEL];
  assign lead_edge  = pin_act && !pin_act_d;
  assign trail_edge = !pin_act && pin_act_d;

  // ==========================================================
  // Phase clock and prescaler
  // phase tick every second system clock
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      phase <= 1'b0;
    else
      phase <= ~phase;
  end

  // ==========================================================
  // Prescaler
  // divide value is product of selected factors
  logic [7:0] div;
  always_comb begin
    div = `TIC_PSC_ONE;
    if (irq_timer_ctrl_port[`TIC_BIT_DIV2])
      div = `TIC_DIV2;
    if (irq_timer_ctrl_port[`TIC_BIT_DIV5])
      div = 8'(div * `TIC_DIV5);
    if (irq_timer_ctrl_port[`TIC_BIT_DIV20])
      div = 8'(div * `TIC_DIV20);
  end

  logic counting;
  logic psc_rst;
  logic psc_tick;
  // pulse mode counts only while pin active
  assign counting = run && ((mode == TIC_MODE_INTERVAL) ||
                            (mode == TIC_MODE_PULSE && pin_act));
  // stopped, port 7 write, pulse trailing edge
  logic rst_stop;
  logic rst_load;
  logic rst_trail;
  assign rst_stop  = !counting;
  assign rst_load  = wr_timer;
  assign rst_trail = (mode == TIC_MODE_PULSE) && trail_edge;
  assign psc_rst   = rst_stop || rst_load || rst_trail;
  assign psc_tick = counting && phase && (psc == 8'(div - `TIC_PSC_ONE));

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      psc <= `TIC_PSC_ZERO;
    else if (psc_rst)
      psc <= `TIC_PSC_ZERO;
    else if (phase)
      psc <= psc_tick ? `TIC_PSC_ZERO : 8'(psc + `TIC_PSC_ONE);
  end

  // ==========================================================
  // Counter and reload register
  logic cnt_step;
  logic wrap;
  // event mode steps on leading edges
  assign cnt_step = (mode == TIC_MODE_EVENT) ? (run && lead_edge) : psc_tick;
  // at 01 the next step reloads
  assign wrap     = cnt_step && (count == `TIC_COUNT_ONE);

  // load takes the byte for the reload register
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      reload <= `TIC_PSC_ZERO;
    else if (wr_timer)
      reload <= IO_REQ_I.data;
  end

  // reload in the tick itself keeps period exact
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      count <= `TIC_PSC_ZERO;
    else if (wr_timer)
      count <= IO_REQ_I.data;
    else if (wrap)
      count <= reload;
    else if (cnt_step)
      count <= 8'(count - `TIC_PSC_ONE);
  end

  // ==========================================================
  // Request latches and acknowledge
  logic ack_t;
  logic ack_e;
  logic take;
  // acknowledge at instruction end while gate flag set
  assign take  = INSTR_DONE_I && IRQ_GATE_FLAG_I;
  // Only a request the CPU can see is taken; the latch
  // guards against a stale output after a clear
  assign ack_t = take && TIMER_IRQ_O && timer_latch;
  assign ack_e = take && EXT_IRQ_O && ext_latch && !TIMER_IRQ_O;

  // set on reload wins; cleared by ack or load
  // Set wins: a reload in the ack cycle is a new
  // request and must not be lost
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      timer_latch <= 1'b0;
    else if (wrap)
      timer_latch <= 1'b1;
    else if (wr_timer || ack_t)
      timer_latch <= 1'b0;
  end

  // edge sets latch while enabled; disable clears
  // Disable wins: a cleared enable must drop the request
  logic ext_set;
  assign ext_set = ext_en && ((mode == TIC_MODE_PULSE) ? trail_edge : lead_edge);
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      ext_latch <= 1'b0;
    else if (!ext_en)
      ext_latch <= 1'b0;
    else if (ext_set)
      ext_latch <= 1'b1;
    else if (ack_e)
      ext_latch <= 1'b0;
  end

  // timer request passed only with bit 1
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      TIMER_IRQ_O <= 1'b0;
    else
      TIMER_IRQ_O <= timer_latch && tmr_en && !ack_t && !wr_timer;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      EXT_IRQ_O <= 1'b0;
    else
      EXT_IRQ_O <= ext_latch && ext_en && !ack_e;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      IRQ_ACK_TIMER_O <= 1'b0;
    else
      IRQ_ACK_TIMER_O <= ack_t;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      IRQ_ACK_EXT_O <= 1'b0;
    else
      IRQ_ACK_EXT_O <= ack_e;
  end

  // ==========================================================
  // Read data
  // port 6 reads pin, port 7 reads count
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I)
      IO_RDATA_O <= `TIC_PSC_ZERO;
    else if (rd_ctrl)
      IO_RDATA_O <= {pin_lvl, 7'h00};
    else if (rd_timer)
      IO_RDATA_O <= count;
    // Other ports and idle cycles read as zero
    else
      IO_RDATA_O <= `TIC_PSC_ZERO;
  end

endmodule : tic_timer
